// File: hdl/tatc_params.svh
// constants of the type a timer control block: offsets, fields, resets
// assumes inclusion by bare name from every file that needs them
`ifndef TATC_PARAMS_SVH
`define TATC_PARAMS_SVH

// register bus layout
`define TATC_ADDR_W 12
`define TATC_OFS_CONTROL 12'h000
`define TATC_OFS_COUNT 12'h004

// control register reset value and writable bits
`define TATC_CTRL_RESET 32'h0000_0000
`define TATC_CTRL_WMASK 32'h0000_B3B6
`define TATC_COUNT_RESET 32'h0000_0000

// control field positions
`define TATC_ON_BIT 15
`define TATC_IDLE_STOP_BIT 13
`define TATC_GUARD_BIT 12
`define TATC_PEND_BIT 11
`define TATC_ECS_LSB 8
`define TATC_GATE_BIT 7
`define TATC_PRESCALE_LSB 4
`define TATC_SYNC_BIT 2
`define TATC_CS_BIT 1

// external clock selection codes
`define TATC_ECS_SOSC 2'h0
`define TATC_ECS_PIN 2'h1
`define TATC_ECS_LOW_POWER_RC_OSCILLATOR 2'h2

// count width and pin index order into the synchroniser
`define TATC_COUNT_W 16
`define TATC_PIN_SOSC 0
`define TATC_PIN_EXT 1
`define TATC_PIN_LOW_POWER_RC_OSCILLATOR 2
`define TATC_PIN_GATE 3
`define TATC_PIN_N 4

`endif

// File: hdl/tatc_pkg.sv
// types shared by the type a timer control block
// assumes nothing beyond a systemverilog compiler
package tatc_pkg;

  // count source actually driving the counter
  typedef enum logic [2:0] {
    TATC_SRC_PCLK,
    TATC_SRC_SOSC,
    TATC_SRC_PIN,
    TATC_SRC_LOW_POWER_RC_OSCILLATOR,
    TATC_SRC_NONE
  } tatc_src_t;

  // state of an asynchronous count register write
  typedef enum logic {
    TATC_WR_IDLE,
    TATC_WR_PEND
  } tatc_wr_state_t;

  // register decode result
  typedef enum logic [1:0] {
    TATC_REG_CONTROL,
    TATC_REG_COUNT,
    TATC_REG_NONE
  } tatc_reg_t;

endpackage

// File: hdl/tatc_sync.sv
// two flip-flop synchroniser with rising edge detect for pin inputs
// assumes inputs are asynchronous to pclk and wider than two pclk periods
`timescale 1ns/10ps
`include "tatc_params.svh"

module tatc_sync #(
  parameter int WIDTH = `TATC_PIN_N
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins
  input wire logic [WIDTH-1:0] async_in,
  // synchronised level and one-cycle rising edge
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] stable_reg;
  logic [WIDTH-1:0] last_reg;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("tatc_sync width must be at least one");
    end
  endgenerate

  // first stage feeds only the second; edges are taken after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      stable_reg <= '0;
      last_reg <= '0;
    end else begin
      meta_reg <= async_in;
      stable_reg <= meta_reg;
      last_reg <= stable_reg;
    end
  end

  // level and edge from settled stages only
  assign level_out = stable_reg;
  assign rise_out = stable_reg & ~last_reg;

endmodule // tatc_sync

// File: hdl/tatc_top.sv
// type a timer control: apb control register, source select, count
// assumes an apb master on pclk and idle_mode from logic on pclk
//
// What this block does
// - timer counts only while enable bit 15 is one
// - idle-stop bit 13 halts counting in idle mode, else keeps running
// - write guard bit 12 drops count writes while one is pending
// - bit 11 reads one while asynchronous count write is pending
// - bit 11 always reads zero in synchronous mode
// - bits 9-8 pick secondary osc, clock pin, low-power rc; 11 reserved
// - gate enable bit 7 ignored when clock source select is one
// - with internal clock, gate bit makes counting follow the gate pin
// - unimplemented control bits read zero and ignore writes
`timescale 1ns/10ps
`include "tatc_params.svh"

module tatc_top #(
  parameter int COUNT_W = `TATC_COUNT_W
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TATC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device power state
  input wire logic idle_mode,
  // clock sources and gate, asynchronous pins
  input wire logic sosc_clk,
  input wire logic external_clock_pin,
  input wire logic low_power_rc_oscillator_clk,
  input wire logic gate_pin,
  // timer state
  output logic [COUNT_W-1:0] count_value,
  output logic count_tick,
  output tatc_pkg::tatc_src_t active_source
);
  import tatc_pkg::*;

  generate
    if (COUNT_W < 2 || COUNT_W > 32) begin : g_bad_count_w
      $error("tatc_top count width must be 2 to 32");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // functions

  // map a byte address onto a register
  function automatic tatc_reg_t decode(input logic [`TATC_ADDR_W-1:0] a);
    if (a == `TATC_OFS_CONTROL) return TATC_REG_CONTROL;
    if (a == `TATC_OFS_COUNT) return TATC_REG_COUNT;
    return TATC_REG_NONE;
  endfunction

  // asynchronous mode: external source with synchronizer off
  function automatic logic is_async(input logic [31:0] c);
    return c[`TATC_CS_BIT] & ~c[`TATC_SYNC_BIT];
  endfunction

  // zero-extend the count onto the data bus
  function automatic logic [31:0] widen(input logic [COUNT_W-1:0] v);
    logic [31:0] r;
    r = '0;
    r[COUNT_W-1:0] = v;
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // declarations

  logic [31:0] ctrl_reg;
  logic [COUNT_W-1:0] count_reg;
  logic [COUNT_W-1:0] wr_value_reg;
  tatc_wr_state_t wr_state_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic tick_reg;
  tatc_src_t src_reg;
  tatc_src_t src_next;
  logic [`TATC_PIN_N-1:0] pin_level;
  logic [`TATC_PIN_N-1:0] pin_rise;
  logic [31:0] ctrl_rd;
  logic xfer;
  logic wr_ctrl;
  logic wr_count;
  logic async_mode;
  logic pend_flag;
  logic accept;
  logic direct_load;
  logic complete;
  logic run;
  logic ext_edge;
  logic tick_next;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  tatc_sync #(
    .WIDTH(`TATC_PIN_N)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({gate_pin, low_power_rc_oscillator_clk, external_clock_pin, sosc_clk}),
    .level_out(pin_level),
    .rise_out(pin_rise)
  );

  //////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, write lands at the completing edge

  assign xfer = psel & penable & pready_reg;
  assign wr_ctrl = xfer & pwrite & (decode(paddr) == TATC_REG_CONTROL);
  assign wr_count = xfer & pwrite & (decode(paddr) == TATC_REG_COUNT);

  // read view: stored bits plus the live pending flag
  always_comb begin
    ctrl_rd = ctrl_reg & `TATC_CTRL_WMASK;
    ctrl_rd[`TATC_PEND_BIT] = pend_flag;
  end

  // pready pulses one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else if (psel && penable && !pready_reg) begin
      pready_reg <= 1'b1;
      pslverr_reg <= (decode(paddr) == TATC_REG_NONE);
      case (decode(paddr))
        TATC_REG_CONTROL: prdata_reg <= pwrite ? '0 : ctrl_rd;
        TATC_REG_COUNT: prdata_reg <= pwrite ? '0 : widen(count_reg);
        default: prdata_reg <= '0;
      endcase
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end
  end

  // control register: only implemented bits take a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `TATC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= pwdata & `TATC_CTRL_WMASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // source selection and tick

  // internal clock or the external source picked by the select field
  always_comb begin
    if (!ctrl_reg[`TATC_CS_BIT]) begin
      src_next = TATC_SRC_PCLK;
    end else begin
      case (ctrl_reg[`TATC_ECS_LSB +: 2])
        `TATC_ECS_SOSC: src_next = TATC_SRC_SOSC;
        `TATC_ECS_PIN: src_next = TATC_SRC_PIN;
        `TATC_ECS_LOW_POWER_RC_OSCILLATOR: src_next = TATC_SRC_LOW_POWER_RC_OSCILLATOR;
        default: src_next = TATC_SRC_NONE;
      endcase
    end
  end

  // edge of the selected external source; reserved code never ticks
  always_comb begin
    case (src_next)
      TATC_SRC_SOSC: ext_edge = pin_rise[`TATC_PIN_SOSC];
      TATC_SRC_PIN: ext_edge = pin_rise[`TATC_PIN_EXT];
      TATC_SRC_LOW_POWER_RC_OSCILLATOR: ext_edge = pin_rise[`TATC_PIN_LOW_POWER_RC_OSCILLATOR];
      default: ext_edge = 1'b0;
    endcase
  end

  // enable, idle stop and gating decide whether this cycle counts
  assign run = ctrl_reg[`TATC_ON_BIT]
    & ~(ctrl_reg[`TATC_IDLE_STOP_BIT] & idle_mode);
  always_comb begin
    if (ctrl_reg[`TATC_CS_BIT]) begin
      tick_next = run & ext_edge;
    end else if (ctrl_reg[`TATC_GATE_BIT]) begin
      tick_next = run & pin_level[`TATC_PIN_GATE];
    end else begin
      tick_next = run;
    end
  end

  // registered copies for the outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_reg <= 1'b0;
      src_reg <= TATC_SRC_PCLK;
    end else begin
      tick_reg <= tick_next;
      src_reg <= src_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // count register writes

  assign async_mode = is_async(ctrl_reg);
  assign pend_flag = (wr_state_reg == TATC_WR_PEND) & async_mode;
  // guard drops a write while one is pending; off, the newer value wins
  assign accept = wr_count
    & ~(ctrl_reg[`TATC_GUARD_BIT] & (wr_state_reg == TATC_WR_PEND));
  assign direct_load = accept & ~async_mode;
  // a pending write lands on the next source edge, or at once if the
  // mode left asynchronous operation meanwhile
  assign complete = (wr_state_reg == TATC_WR_PEND)
    & (ext_edge | ~async_mode) & ~direct_load;

  // pending write tracker; a new write in the completing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_state_reg <= TATC_WR_IDLE;
      wr_value_reg <= '0;
    end else if (accept && async_mode) begin
      wr_state_reg <= TATC_WR_PEND;
      wr_value_reg <= pwdata[COUNT_W-1:0];
    end else if (complete || direct_load) begin
      wr_state_reg <= TATC_WR_IDLE;
    end
  end

  // counter: loads have priority over the tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else if (direct_load) begin
      count_reg <= pwdata[COUNT_W-1:0];
    end else if (complete) begin
      count_reg <= wr_value_reg;
    end else if (tick_next) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign count_value = count_reg;
  assign count_tick = tick_reg;
  assign active_source = src_reg;

  //////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_off_holds: assert property (
    !ctrl_reg[`TATC_ON_BIT] && !direct_load && !complete
    |=> $stable(count_reg))
    else $error("count moved while timer off");
  a_on_counts: assert property (
    run && !ctrl_reg[`TATC_CS_BIT]
    && !ctrl_reg[`TATC_GATE_BIT] && !direct_load && !complete
    |=> count_reg == COUNT_W'($past(count_reg) + 1'b1))
    else $error("enabled internal count did not step");
  a_idle_halt: assert property (
    ctrl_reg[`TATC_IDLE_STOP_BIT] && idle_mode
    && !direct_load && !complete |=> $stable(count_reg))
    else $error("count moved in idle with idle stop");
  a_idle_runs: assert property (
    ctrl_reg[`TATC_ON_BIT] && idle_mode
    && !ctrl_reg[`TATC_IDLE_STOP_BIT] && !ctrl_reg[`TATC_CS_BIT]
    && !ctrl_reg[`TATC_GATE_BIT] |=> count_tick)
    else $error("idle stopped timer without idle stop");
  a_guard_block: assert property (
    wr_count && ctrl_reg[`TATC_GUARD_BIT]
    && wr_state_reg == TATC_WR_PEND |=> $stable(wr_value_reg))
    else $error("guarded write replaced pending value");
  a_pending_shown: assert property (
    accept && async_mode |=> ctrl_rd[`TATC_PEND_BIT])
    else $error("pending flag not set after async write");
  // watched on the bus read data, not on the flag's own expression
  a_sync_zero: assert property (
    psel && penable && !pready_reg && !pwrite
    && paddr == `TATC_OFS_CONTROL && !async_mode
    |=> !prdata_reg[`TATC_PEND_BIT])
    else $error("pending flag set in synchronous mode");
  a_src_decode: assert property (
    ctrl_reg[`TATC_CS_BIT]
    && ctrl_reg[`TATC_ECS_LSB +: 2] == `TATC_ECS_PIN
    ##1 $stable(ctrl_reg) |-> active_source == TATC_SRC_PIN)
    else $error("clock pin not selected");
  a_gate_ignored: assert property (
    ctrl_reg[`TATC_CS_BIT] && run && ext_edge |=> count_tick)
    else $error("gate affected external clocking");
  a_gate_blocks: assert property (
    !ctrl_reg[`TATC_CS_BIT]
    && ctrl_reg[`TATC_GATE_BIT] && !pin_level[`TATC_PIN_GATE]
    |=> !count_tick)
    else $error("counted with gate inactive");
  a_reserved_zero: assert property (
    (ctrl_rd & ~`TATC_CTRL_WMASK) == (32'(pend_flag) << `TATC_PEND_BIT))
    else $error("unimplemented control bit set");
  // a new write in the landing cycle may legally re-arm pending
  a_async_load: assert property (
    wr_state_reg == TATC_WR_PEND
    && async_mode && ext_edge && !direct_load && !accept
    |=> count_reg == $past(wr_value_reg)
    && wr_state_reg == TATC_WR_IDLE)
    else $error("async write did not land on source edge");
  a_apb_wait: assert property (psel && penable && !pready_reg
    |=> pready_reg ##1 !pready_reg)
    else $error("apb answer not one wait state");

  c_async_write: cover property (accept && async_mode ##[1:50] complete);
  c_gated_count: cover property (ctrl_reg[`TATC_GATE_BIT] && tick_next);
  c_guard_drop: cover property (wr_count && !accept);
  c_idle_stop: cover property (ctrl_reg[`TATC_ON_BIT] && !run);

endmodule // tatc_top

// File: verification/tatc_src_model.sv
// stand-in for the clock source pins and gate pin of the timer
// assumes pulses are commanded by the bench; pins idle low otherwise
`timescale 1ns/10ps
`include "tatc_params.svh"

module tatc_src_model (
  // clock
  input wire logic pclk,
  // pins toward the block
  output logic sosc_clk,
  output logic external_clock_pin,
  output logic low_power_rc_oscillator_clk,
  output logic gate_pin
);
  logic [`TATC_PIN_N-1:0] pins = '0;

  // sources stand still between pulses so every edge is accounted for
  assign sosc_clk = pins[`TATC_PIN_SOSC];
  assign external_clock_pin = pins[`TATC_PIN_EXT];
  assign low_power_rc_oscillator_clk = pins[`TATC_PIN_LOW_POWER_RC_OSCILLATOR];
  assign gate_pin = pins[`TATC_PIN_GATE];

  // high for 4 cycles and low for 5: the synchroniser needs at least 2
  task automatic pulse(input int idx);
    @(posedge pclk);
    pins[idx] <= 1'b1;
    repeat (4) @(posedge pclk);
    pins[idx] <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask

  // gate level change, then time for the two-flop sync to settle
  task automatic set_gate(input logic v);
    @(posedge pclk);
    pins[`TATC_PIN_GATE] <= v;
    repeat (4) @(posedge pclk);
  endtask
endmodule // tatc_src_model

// File: verification/tb.sv
// self-checking bench for the type a timer control block
// assumes the source model above and the apb timing in the hand-over
`timescale 1ns/10ps
`include "tatc_params.svh"

module tb;
  import tatc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic idle_mode = 0, pready, pslverr, err, count_tick;
  logic [`TATC_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic sosc_clk, external_clock_pin, low_power_rc_oscillator_clk, gate_pin;
  logic [15:0] count_value, c0;
  tatc_src_t active_source;
  int error_cnt = 0, total_checks = 0;
  localparam logic [11:0] CT = `TATC_OFS_CONTROL;
  localparam logic [11:0] CN = `TATC_OFS_COUNT;

  always #2 pclk = ~pclk;

  tatc_src_model src (.pclk(pclk), .sosc_clk(sosc_clk),
    .external_clock_pin(external_clock_pin), .low_power_rc_oscillator_clk(low_power_rc_oscillator_clk),
    .gate_pin(gate_pin));
  tatc_top #(.COUNT_W(16)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .idle_mode(idle_mode), .sosc_clk(sosc_clk),
    .external_clock_pin(external_clock_pin), .low_power_rc_oscillator_clk(low_power_rc_oscillator_clk),
    .gate_pin(gate_pin), .count_value(count_value),
    .count_tick(count_tick), .active_source(active_source));

  ////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) chk("pready", 1, 0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a,
                       input logic [31:0] e);
    apb(0, a, 0);
    chk(nm, e, rd);
  endtask

  // count must move by exactly dlt over n cycles
  task automatic run(input int n, input int dlt, input string nm);
    @(posedge pclk);
    #1 c0 = count_value;
    repeat (n) @(posedge pclk);
    #1 chk(nm, {16'h0000, c0 + dlt[15:0]}, {16'h0000, count_value});
  endtask

  ////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    rdchk("ctrl reset", CT, `TATC_CTRL_RESET);
    apb(1, CT, 32'hFFFF_FFFF);
    rdchk("ctrl mask", CT, 32'h0000_B3B6);
    chk("src none", TATC_SRC_NONE, {29'h0, active_source});
    apb(0, 12'h008, 0);
    chk("unmapped err", 1, {31'h0, err});
    chk("unmapped data", 0, rd);
    apb(1, CT, 0);
  endtask

  task automatic t_on_idle_gate();
    apb(1, CT, 32'h0000_8000);
    chk("src pclk", TATC_SRC_PCLK, {29'h0, active_source});
    run(10, 10, "on count");
    chk("tick on", 1, {31'h0, count_tick});
    apb(1, CT, 0);
    run(10, 0, "off count");
    chk("tick off", 0, {31'h0, count_tick});
    apb(1, CT, 32'h0000_A000);
    idle_mode <= 1'b1;
    run(10, 0, "idle stop");
    apb(1, CT, 32'h0000_8000);
    run(10, 10, "idle run");
    idle_mode <= 1'b0;
    apb(1, CT, 32'h0000_8080);
    src.set_gate(0);
    run(10, 0, "gate low");
    src.set_gate(1);
    run(10, 10, "gate high");
    src.set_gate(0);
  endtask

  // gate bit set with gate low: external counting must not care
  task automatic t_ext();
    tatc_src_t es[4] = '{TATC_SRC_SOSC, TATC_SRC_PIN, TATC_SRC_LOW_POWER_RC_OSCILLATOR,
                         TATC_SRC_NONE};
    int px[4] = '{`TATC_PIN_SOSC, `TATC_PIN_EXT, `TATC_PIN_LOW_POWER_RC_OSCILLATOR,
                  `TATC_PIN_EXT};
    for (int i = 0; i < 4; i++) begin
      apb(1, CT, 32'h0000_8086 | (i << 8));
      // the selection reaches the output one edge after the write lands
      @(posedge pclk);
      #1 chk("source", es[i], {29'h0, active_source});
      c0 = count_value;
      // an unselected source must not move the count
      src.pulse(px[3 - i]);
      repeat (3) src.pulse(px[i]);
      chk("ext count", {16'h0, c0 + ((i < 3) ? 16'd3 : 16'd0)},
          {16'h0, count_value});
    end
  endtask

  task automatic t_async();
    apb(1, CT, 32'h0000_8102);
    apb(1, CN, 32'h0000_1234);
    apb(1, CN, 32'h0000_2222);
    rdchk("pending set", CT, 32'h0000_8902);
    src.pulse(`TATC_PIN_EXT);
    rdchk("legacy write", CN, 32'h0000_2222);
    rdchk("pending clr", CT, 32'h0000_8102);
    apb(1, CT, 32'h0000_9102);
    apb(1, CN, 32'h0000_3333);
    apb(1, CN, 32'h0000_4444);
    src.pulse(`TATC_PIN_EXT);
    rdchk("guarded write", CN, 32'h0000_3333);
    apb(1, CN, 32'h0000_0042);
    apb(1, CT, 32'h0000_8106);
    rdchk("mode exit load", CN, 32'h0000_0042);
    apb(1, CN, 32'h0000_0055);
    rdchk("sync pending", CT, 32'h0000_8106);
    rdchk("sync load", CN, 32'h0000_0055);
  endtask

  ////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_on_idle_gate();
    t_ext();
    t_async();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    close_out();
  end
endmodule // tb
